// ### inc/vxcr_map.vh
// register indices, field positions and reset values of the extended control bank
`ifndef VXCR_MAP_VH
`define VXCR_MAP_VH
`define VXCR_IDX_DISP_ADDR_EXT   8'h30
`define VXCR_IDX_COMPAT_SCAN     8'h31
`define VXCR_IDX_CPU_PAGE        8'h32
`define VXCR_IDX_EEPROM_MEMW     8'h33
`define VXCR_IDX_CRTC_WP         8'h34
`define VXCR_IDX_BLANK_CURSOR    8'h35
`define VXCR_IDX_LINEAR_ADDR     8'h36
`define VXCR_REG_COUNT           7
`define VXCR_RESET_VAL           8'h00
// display_address_ext
`define VXCR_B_CURSOR_A16        2
`define VXCR_B_RESV_1MB          3
`define VXCR_B_RESV_512K         4
`define VXCR_B_EXT_256COLOR      5
`define VXCR_B_START_A16         6
// compat_scan_control
`define VXCR_B_EGA_IO            0
`define VXCR_B_EGA_REGS          1
`define VXCR_F_SCAN_HI           5
`define VXCR_F_SCAN_LO           3
`define VXCR_B_VTIME_DIV2        6
// scan function codes
`define VXCR_SCAN_NORMAL         3'h0
`define VXCR_SCAN_GR_DOUBLE      3'h1
`define VXCR_SCAN_GR_3OF4        3'h2
`define VXCR_SCAN_TX_DOUBLE      3'h5
`define VXCR_SCAN_TX_3OF4        3'h6
// cpu_page_select
`define VXCR_F_WPAGE_HI          4
`define VXCR_F_WPAGE_LO          1
`define VXCR_F_WPAGE_LOW3_HI     3
`define VXCR_F_RPAGE_HI          7
`define VXCR_F_RPAGE_LO          5
// eeprom_memwidth_control
`define VXCR_B_EE_DATA           0
`define VXCR_B_EE_CLOCK          1
`define VXCR_B_EE_SELECT         3
`define VXCR_B_MEMWIDTH          5
`define VXCR_B_ONE_BIT_MAP       6
`define VXCR_B_SHORT_DBLSCAN     7
// crtc_write_protect
`define VXCR_B_WP_MAXSCAN        2
`define VXCR_B_WP_VTIMING        3
`define VXCR_B_WP_CURSOR         4
`define VXCR_B_WP_ROW_UL         5
`define VXCR_B_WP_HTIMING        6
// blanking_cursor_control
`define VXCR_B_BLANK_DE          0
`define VXCR_B_BLANK_INV         1
`define VXCR_B_CURSOR_PLUS5      6
`define VXCR_CURSOR_OFFSET       5'h05
// linear_addr_control
`define VXCR_B_ADDR_ABOVE_64K    0
`define VXCR_B_LINEAR_256        2
`endif

// ### verilog/vxcr_ext_regs.v
// indexed extended control register bank with decoded control outputs
`timescale 1ns/10ps
`include "vxcr_map.vh"

// Functional notes
// - in extended modes cursor and start address bit 16 come from display_address_ext.
// - reserved vga memory: bit3 gives 1MB, else bit4 picks 512KB or 256KB.
// - bit 5 forces 256-color pixel mode while in extended modes.
// - bit 0 remaps I/O decodes to EGA addresses; bit 1 makes registers EGA-like.
// - general-purpose bits store and read back writes with no side effect.
// - 3-bit scan field selects normal, double or 3-of-4 scanning per mode.
// - compat bit 6 halves vertical timing parameters, else current clock rate.
// - write page bits 4:1 select one of sixteen blocks, 0 to 15, of 64K or 128K.
// - with separate paging off, low three write-page bits 3:1 page reads; writes use all four.
// - with separate paging on, bits 7:5 select the read page.
// - 128K aperture enable switches page granularity between 64K and 128K.
// - EEPROM data, clock and select pins follow register bits 0, 1 and 3.
// - memory width bit meaning inverts when the board strap pulls low.
// - EEPROM register bit 6 enables one-bit-per-map memory mapping.
// - EEPROM register bit 7 double-scans screens of 150 to 250 lines.
// - write-protect bit 3 blocks writes to vertical timing CRTC fields.
// - write-protect bit 6 guards horizontal CRTC 00..07, bit 4 of 07 excepted.
// - bits 2, 4 and 5 guard max-scan, cursor, preset-row and underline fields.
// - blanking bit 0 sends display enable as blank, bit 1 inverts the pin.
// - blanking bit 6 adds five to cursor start and end scan lines.
// - addressing bit 0 lets the display address counter pass 64KB.
// - addressing bit 2 selects linear addressing in 256-color mode.
// - one indexed port; 16-bit write carries index low, data high.
module vxcr_ext_regs (
   clock,
   reset,
   io_index,
   io_wdata,
   io_write,
   io_rdata,
   ext_mode,
   graphics_mode,
   separate_paging_select_reg,
   aperture_128k_enable_reg,
   memwidth_strap_pin,
   display_enable,
   cursor_start_in,
   cursor_end_in,
   cursor_addr_a16,
   start_addr_a16,
   vga_mem_reserve,
   pixel_256color,
   ega_io_decode,
   ega_reg_compat,
   scan_double,
   scan_3of4,
   vtiming_div2,
   write_block,
   read_block,
   block_128k,
   eeprom_data,
   eeprom_clock,
   eeprom_select,
   mem_16bit,
   one_bit_per_map,
   short_screen_dblscan,
   wp_vtiming,
   wp_htiming,
   wp_max_scan,
   wp_cursor,
   wp_row_underline,
   blank_out_n,
   cursor_start_out,
   cursor_end_out,
   addr_above_64k,
   linear_256
);
   input  wire       clock;
   input  wire       reset;
   input  wire [7:0] io_index;
   input  wire [7:0] io_wdata;
   input  wire       io_write;
   output reg  [7:0] io_rdata;
   input  wire       ext_mode;
   input  wire       graphics_mode;
   input  wire       separate_paging_select_reg;
   input  wire       aperture_128k_enable_reg;
   input  wire       memwidth_strap_pin;
   input  wire       display_enable;
   input  wire [4:0] cursor_start_in;
   input  wire [4:0] cursor_end_in;
   output reg        cursor_addr_a16;
   output reg        start_addr_a16;
   output reg  [1:0] vga_mem_reserve;
   output reg        pixel_256color;
   output reg        ega_io_decode;
   output reg        ega_reg_compat;
   output reg        scan_double;
   output reg        scan_3of4;
   output reg        vtiming_div2;
   output reg  [3:0] write_block;
   output reg  [3:0] read_block;
   output reg        block_128k;
   output reg        eeprom_data;
   output reg        eeprom_clock;
   output reg        eeprom_select;
   output reg        mem_16bit;
   output reg        one_bit_per_map;
   output reg        short_screen_dblscan;
   output reg        wp_vtiming;
   output reg        wp_htiming;
   output reg        wp_max_scan;
   output reg        wp_cursor;
   output reg        wp_row_underline;
   output reg        blank_out_n;
   output reg  [4:0] cursor_start_out;
   output reg  [4:0] cursor_end_out;
   output reg        addr_above_64k;
   output reg        linear_256;

   // vga_mem_reserve codes
   localparam [1:0] RESV_256K = 2'h0;
   localparam [1:0] RESV_512K = 2'h1;
   localparam [1:0] RESV_1MB  = 2'h2;

   reg  [7:0] display_address_ext_reg;
   reg  [7:0] compat_scan_control_reg;
   reg  [7:0] cpu_page_select_reg;
   reg  [7:0] eeprom_memwidth_control_reg;
   reg  [7:0] crtc_write_protect_reg;
   reg  [7:0] blanking_cursor_control_reg;
   reg  [7:0] linear_addr_control_reg;

   // strap synchroniser, three stages
   reg        strap_s1_reg;
   reg        strap_s2_reg;
   reg        strap_s3_reg;
   reg        strap_low_reg;

   // one write enable per register of the bank
   wire [`VXCR_REG_COUNT-1:0] wr_en;

   // index match helper
   function hit;
      input [7:0] idx;
      input [7:0] target;
      begin
         hit = (idx == target);
      end
   endfunction

   // index of the n-th register, indices run consecutively
   function [7:0] idx_of;
      input integer n;
      begin
         idx_of = `VXCR_IDX_DISP_ADDR_EXT + n[7:0];
      end
   endfunction

   // write enable decode per register
   genvar gi;
   generate
      for (gi = 0; gi < `VXCR_REG_COUNT; gi = gi + 1) begin : g_wr_en
         assign wr_en[gi] = io_write & hit(io_index, idx_of(gi));
      end
   endgenerate

   // register writes, index in low byte and data in high byte
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         display_address_ext_reg     <= `VXCR_RESET_VAL;
         compat_scan_control_reg     <= `VXCR_RESET_VAL;
         cpu_page_select_reg         <= `VXCR_RESET_VAL;
         eeprom_memwidth_control_reg <= `VXCR_RESET_VAL;
         crtc_write_protect_reg      <= `VXCR_RESET_VAL;
         blanking_cursor_control_reg <= `VXCR_RESET_VAL;
         linear_addr_control_reg     <= `VXCR_RESET_VAL;
      end else begin
         if (wr_en[0])
            display_address_ext_reg <= io_wdata;
         if (wr_en[1])
            compat_scan_control_reg <= io_wdata;
         if (wr_en[2])
            cpu_page_select_reg <= io_wdata;
         if (wr_en[3])
            eeprom_memwidth_control_reg <= io_wdata;
         if (wr_en[4])
            crtc_write_protect_reg <= io_wdata;
         if (wr_en[5])
            blanking_cursor_control_reg <= io_wdata;
         if (wr_en[6])
            linear_addr_control_reg <= io_wdata;
      end
   end

   // read back of the indexed register
   always @* begin
      case (io_index)
         `VXCR_IDX_DISP_ADDR_EXT: io_rdata = display_address_ext_reg;
         `VXCR_IDX_COMPAT_SCAN:   io_rdata = compat_scan_control_reg;
         `VXCR_IDX_CPU_PAGE:      io_rdata = cpu_page_select_reg;
         `VXCR_IDX_EEPROM_MEMW:   io_rdata = eeprom_memwidth_control_reg;
         `VXCR_IDX_CRTC_WP:       io_rdata = crtc_write_protect_reg;
         `VXCR_IDX_BLANK_CURSOR:  io_rdata = blanking_cursor_control_reg;
         `VXCR_IDX_LINEAR_ADDR:   io_rdata = linear_addr_control_reg;
         default:                 io_rdata = `VXCR_RESET_VAL;
      endcase
   end

   // strap sampling
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         strap_s1_reg  <= 1'b1;
         strap_s2_reg  <= 1'b1;
         strap_s3_reg  <= 1'b1;
         strap_low_reg <= 1'b0;
      end else begin
         strap_s1_reg <= memwidth_strap_pin;
         strap_s2_reg <= strap_s1_reg;
         strap_s3_reg <= strap_s2_reg;
         if (strap_s2_reg == strap_s3_reg)
            strap_low_reg <= ~strap_s3_reg;
      end
   end

   // address bit 16, memory reserve and pixel mode
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         cursor_addr_a16 <= 1'b0;
         start_addr_a16  <= 1'b0;
         vga_mem_reserve <= RESV_256K;
         pixel_256color  <= 1'b0;
      end else begin
         cursor_addr_a16 <= ext_mode &
            display_address_ext_reg[`VXCR_B_CURSOR_A16];
         start_addr_a16 <= ext_mode &
            display_address_ext_reg[`VXCR_B_START_A16];
         if (display_address_ext_reg[`VXCR_B_RESV_1MB])
            vga_mem_reserve <= RESV_1MB;
         else if (display_address_ext_reg[`VXCR_B_RESV_512K])
            vga_mem_reserve <= RESV_512K;
         else
            vga_mem_reserve <= RESV_256K;
         pixel_256color <= ext_mode &
            display_address_ext_reg[`VXCR_B_EXT_256COLOR];
      end
   end

   // compatibility, scan function and vertical timing
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         ega_io_decode  <= 1'b0;
         ega_reg_compat <= 1'b0;
         scan_double    <= 1'b0;
         scan_3of4      <= 1'b0;
         vtiming_div2   <= 1'b0;
      end else begin
         ega_io_decode  <= compat_scan_control_reg[`VXCR_B_EGA_IO];
         ega_reg_compat <= compat_scan_control_reg[`VXCR_B_EGA_REGS];
         case (compat_scan_control_reg[`VXCR_F_SCAN_HI:`VXCR_F_SCAN_LO])
            `VXCR_SCAN_GR_DOUBLE: begin
               scan_double <= graphics_mode;
               scan_3of4   <= 1'b0;
            end
            `VXCR_SCAN_GR_3OF4: begin
               scan_double <= 1'b0;
               scan_3of4   <= graphics_mode;
            end
            `VXCR_SCAN_TX_DOUBLE: begin
               scan_double <= ~graphics_mode;
               scan_3of4   <= 1'b0;
            end
            `VXCR_SCAN_TX_3OF4: begin
               scan_double <= 1'b0;
               scan_3of4   <= ~graphics_mode;
            end
            default: begin
               scan_double <= 1'b0;
               scan_3of4   <= 1'b0;
            end
         endcase
         vtiming_div2 <= compat_scan_control_reg[`VXCR_B_VTIME_DIV2];
      end
   end

   // cpu aperture paging
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         write_block <= 4'h0;
         read_block  <= 4'h0;
         block_128k  <= 1'b0;
      end else begin
         write_block <=
            cpu_page_select_reg[`VXCR_F_WPAGE_HI:`VXCR_F_WPAGE_LO];
         if (separate_paging_select_reg)
            read_block <= {1'b0,
               cpu_page_select_reg[`VXCR_F_RPAGE_HI:`VXCR_F_RPAGE_LO]};
         else
            read_block <= {1'b0,
               cpu_page_select_reg[`VXCR_F_WPAGE_LOW3_HI:`VXCR_F_WPAGE_LO]};
         block_128k    <= aperture_128k_enable_reg;
      end
   end

   // serial eeprom pins
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         eeprom_data   <= 1'b0;
         eeprom_clock  <= 1'b0;
         eeprom_select <= 1'b0;
      end else begin
         eeprom_data   <= eeprom_memwidth_control_reg[`VXCR_B_EE_DATA];
         eeprom_clock  <= eeprom_memwidth_control_reg[`VXCR_B_EE_CLOCK];
         eeprom_select <= eeprom_memwidth_control_reg[`VXCR_B_EE_SELECT];
      end
   end

   // memory width and mode bits
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         mem_16bit            <= 1'b0;
         one_bit_per_map      <= 1'b0;
         short_screen_dblscan <= 1'b0;
      end else begin
         mem_16bit <= eeprom_memwidth_control_reg[`VXCR_B_MEMWIDTH] ^
            strap_low_reg;
         one_bit_per_map <=
            eeprom_memwidth_control_reg[`VXCR_B_ONE_BIT_MAP];
         short_screen_dblscan <=
            eeprom_memwidth_control_reg[`VXCR_B_SHORT_DBLSCAN];
      end
   end

   // crtc write protect levels
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         wp_vtiming       <= 1'b0;
         wp_htiming       <= 1'b0;
         wp_max_scan      <= 1'b0;
         wp_cursor        <= 1'b0;
         wp_row_underline <= 1'b0;
      end else begin
         wp_vtiming       <= crtc_write_protect_reg[`VXCR_B_WP_VTIMING];
         wp_htiming       <= crtc_write_protect_reg[`VXCR_B_WP_HTIMING];
         wp_max_scan      <= crtc_write_protect_reg[`VXCR_B_WP_MAXSCAN];
         wp_cursor        <= crtc_write_protect_reg[`VXCR_B_WP_CURSOR];
         wp_row_underline <= crtc_write_protect_reg[`VXCR_B_WP_ROW_UL];
      end
   end

   // blanking output
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         blank_out_n <= 1'b1;
      end else begin
         blank_out_n <= (blanking_cursor_control_reg[`VXCR_B_BLANK_DE] ?
            display_enable : 1'b1) ^
            blanking_cursor_control_reg[`VXCR_B_BLANK_INV];
      end
   end

   // cursor scan-line offset
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         cursor_start_out <= 5'h00;
         cursor_end_out   <= 5'h00;
      end else begin
         if (blanking_cursor_control_reg[`VXCR_B_CURSOR_PLUS5]) begin
            cursor_start_out <= cursor_start_in + `VXCR_CURSOR_OFFSET;
            cursor_end_out   <= cursor_end_in + `VXCR_CURSOR_OFFSET;
         end else begin
            cursor_start_out <= cursor_start_in;
            cursor_end_out   <= cursor_end_in;
         end
      end
   end

   // linear addressing controls
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         addr_above_64k <= 1'b0;
         linear_256     <= 1'b0;
      end else begin
         addr_above_64k <=
            linear_addr_control_reg[`VXCR_B_ADDR_ABOVE_64K];
         linear_256 <= linear_addr_control_reg[`VXCR_B_LINEAR_256];
      end
   end
endmodule // vxcr_ext_regs

// ### verification/vxcr_ext_regs_asserts.sv
// concurrent checks on the extended control register bank ports
`timescale 1ns/10ps
module vxcr_ext_regs_chk (
   input wire logic       clock,
   input wire logic       reset,
   input wire logic [7:0] io_index,
   input wire logic [7:0] io_wdata,
   input wire logic       io_write,
   input wire logic [7:0] io_rdata,
   input wire logic       ext_mode,
   input wire logic       graphics_mode,
   input wire logic       separate_paging_select_reg,
   input wire logic       aperture_128k_enable_reg,
   input wire logic       display_enable,
   input wire logic [4:0] cursor_start_in,
   input wire logic       cursor_addr_a16,
   input wire logic [1:0] vga_mem_reserve,
   input wire logic       scan_double,
   input wire logic [3:0] write_block,
   input wire logic [3:0] read_block,
   input wire logic       block_128k,
   input wire logic       eeprom_data,
   input wire logic       eeprom_select,
   input wire logic       blank_out_n,
   input wire logic [4:0] cursor_start_out
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   // write taken, then two edges to the decoded output
   sequence s_wr(logic [7:0] idx);
      io_write && io_index == idx ##2 1'b1;
   endsequence
   property p_rdback;
      io_write && io_index inside {[8'h30:8'h36]} ##1 io_index == $past(io_index)
         |-> io_rdata == $past(io_wdata);
   endproperty
   property p_unmapped;
      !(io_index inside {[8'h30:8'h36]}) |-> io_rdata == 8'h00;
   endproperty
   property p_reset;
      disable iff (1'b0) reset |=> io_rdata == 8'h00 && blank_out_n && !eeprom_select;
   endproperty
   property p_a16;
      s_wr(8'h30) |-> cursor_addr_a16 == ($past(io_wdata[2], 2) && $past(ext_mode));
   endproperty
   property p_resv;
      s_wr(8'h30) |-> vga_mem_reserve == ($past(io_wdata[3], 2) ? 2'h2 : {1'b0, $past(io_wdata[4], 2)});
   endproperty
   property p_scan;
      s_wr(8'h31) |-> scan_double == (($past(io_wdata[5:3], 2) == 3'h1 && $past(graphics_mode))
         || ($past(io_wdata[5:3], 2) == 3'h5 && !$past(graphics_mode)));
   endproperty
   property p_page;
      s_wr(8'h32) |-> write_block == $past(io_wdata[4:1], 2) && read_block ==
         ($past(separate_paging_select_reg) ? {1'b0, $past(io_wdata[7:5], 2)}
                                            : {1'b0, $past(io_wdata[3:1], 2)});
   endproperty
   property p_gran;
      1'b1 |=> block_128k == $past(aperture_128k_enable_reg);
   endproperty
   property p_pins;
      s_wr(8'h33) |-> {eeprom_select, eeprom_data} == {$past(io_wdata[3], 2), $past(io_wdata[0], 2)};
   endproperty
   property p_blank;
      s_wr(8'h35) |-> blank_out_n ==
         (($past(io_wdata[0], 2) ? $past(display_enable) : 1'b1) ^ $past(io_wdata[1], 2));
   endproperty
   property p_cursor;
      s_wr(8'h35) |-> cursor_start_out ==
         ($past(io_wdata[6], 2) ? $past(cursor_start_in) + 5'h05 : $past(cursor_start_in));
   endproperty
   a_rdback: assert property (p_rdback) else $error("read back differs");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_reset: assert property (p_reset) else $error("reset state wrong");
   a_a16: assert property (p_a16) else $error("cursor bit 16 wrong");
   a_resv: assert property (p_resv) else $error("memory reserve wrong");
   a_scan: assert property (p_scan) else $error("double scan wrong");
   a_page: assert property (p_page) else $error("page select wrong");
   a_gran: assert property (p_gran) else $error("granularity wrong");
   a_pins: assert property (p_pins) else $error("eeprom pins wrong");
   a_blank: assert property (p_blank) else $error("blank output wrong");
   a_cursor: assert property (p_cursor) else $error("cursor offset wrong");
endmodule // vxcr_ext_regs_chk

bind vxcr_ext_regs vxcr_ext_regs_chk u_chk (
   .clock(clock), .reset(reset), .io_index(io_index), .io_wdata(io_wdata),
   .io_write(io_write), .io_rdata(io_rdata), .ext_mode(ext_mode),
   .graphics_mode(graphics_mode), .separate_paging_select_reg(separate_paging_select_reg),
   .aperture_128k_enable_reg(aperture_128k_enable_reg), .display_enable(display_enable),
   .cursor_start_in(cursor_start_in), .cursor_addr_a16(cursor_addr_a16),
   .vga_mem_reserve(vga_mem_reserve), .scan_double(scan_double),
   .write_block(write_block), .read_block(read_block), .block_128k(block_128k),
   .eeprom_data(eeprom_data), .eeprom_select(eeprom_select), .blank_out_n(blank_out_n),
   .cursor_start_out(cursor_start_out)
);

// ### verification/vxcr_tb.sv
// self-checking bench for the extended control register bank
`timescale 1ns/10ps
module tb;
   logic       clock = 1'b0;
   logic       reset = 1'b1;
   logic [7:0] io_index = 8'h00, io_wdata = 8'h00, io_rdata, d;
   logic       io_write = 1'b0, ext_mode = 1'b0, graphics_mode = 1'b0;
   logic       separate_paging_select_reg = 1'b0, aperture_128k_enable_reg = 1'b0;
   logic       memwidth_strap_pin = 1'b1, display_enable = 1'b0;
   logic [4:0] cursor_start_in = 5'h1D, cursor_end_in = 5'h03, cursor_start_out, cursor_end_out;
   logic       cursor_addr_a16, start_addr_a16, pixel_256color, ega_io_decode, ega_reg_compat;
   logic       scan_double, scan_3of4, vtiming_div2, block_128k, eeprom_data, eeprom_clock;
   logic       eeprom_select, mem_16bit, one_bit_per_map, short_screen_dblscan, wp_vtiming;
   logic       wp_htiming, wp_max_scan, wp_cursor, wp_row_underline, blank_out_n;
   logic       addr_above_64k, linear_256;
   logic [1:0] vga_mem_reserve;
   logic [3:0] write_block, read_block;
   integer     err_total = 0, samples_checked = 0, i;
   vxcr_ext_regs dut (
      .clock(clock), .reset(reset), .io_index(io_index), .io_wdata(io_wdata),
      .io_write(io_write), .io_rdata(io_rdata), .ext_mode(ext_mode),
      .graphics_mode(graphics_mode), .separate_paging_select_reg(separate_paging_select_reg),
      .aperture_128k_enable_reg(aperture_128k_enable_reg),
      .memwidth_strap_pin(memwidth_strap_pin), .display_enable(display_enable),
      .cursor_start_in(cursor_start_in), .cursor_end_in(cursor_end_in),
      .cursor_addr_a16(cursor_addr_a16), .start_addr_a16(start_addr_a16),
      .vga_mem_reserve(vga_mem_reserve), .pixel_256color(pixel_256color),
      .ega_io_decode(ega_io_decode), .ega_reg_compat(ega_reg_compat),
      .scan_double(scan_double), .scan_3of4(scan_3of4), .vtiming_div2(vtiming_div2),
      .write_block(write_block), .read_block(read_block), .block_128k(block_128k),
      .eeprom_data(eeprom_data), .eeprom_clock(eeprom_clock), .eeprom_select(eeprom_select),
      .mem_16bit(mem_16bit), .one_bit_per_map(one_bit_per_map),
      .short_screen_dblscan(short_screen_dblscan), .wp_vtiming(wp_vtiming),
      .wp_htiming(wp_htiming), .wp_max_scan(wp_max_scan), .wp_cursor(wp_cursor),
      .wp_row_underline(wp_row_underline), .blank_out_n(blank_out_n),
      .cursor_start_out(cursor_start_out), .cursor_end_out(cursor_end_out),
      .addr_above_64k(addr_above_64k), .linear_256(linear_256)
   );
   initial forever #12.5 clock = ~clock;
   task chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task wr(input logic [7:0] idx, input logic [7:0] v);
      @(posedge clock);
      io_index <= idx;
      io_wdata <= v;
      io_write <= 1'b1;
      @(posedge clock);
      io_write <= 1'b0;
   endtask
   task rd(input logic [7:0] idx, input logic [7:0] exp);
      @(posedge clock);
      io_index <= idx;
      #1 chk("io_rdata", exp, io_rdata);
   endtask
   task settle;
      repeat (3) @(posedge clock);
      #1;
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #100000;
      err_total = err_total + 1;
      final_report;
   end
   initial begin
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      for (i = 0; i < 8; i = i + 1) rd(8'h30 + i[7:0], 8'h00);
      chk("blank_out_n", 8'h01, {7'h00, blank_out_n});
      $display("test reset done");
      for (i = 0; i < 7; i = i + 1) wr(8'h30 + i[7:0], 8'h5A ^ i[7:0]);
      wr(8'h37, 8'hFF);
      for (i = 0; i < 8; i = i + 1) rd(8'h30 + i[7:0], (i < 7) ? 8'h5A ^ i[7:0] : 8'h00);
      $display("test readback done");
      @(posedge clock);
      ext_mode <= 1'b1;
      wr(8'h30, 8'h7C);
      settle;
      chk("ext30", 8'h0F, {4'h0, cursor_addr_a16, start_addr_a16, pixel_256color, 1'b1});
      chk("vga_mem_reserve", 8'h02, {6'h00, vga_mem_reserve});
      wr(8'h30, 8'h10);
      settle;
      chk("vga_mem_reserve", 8'h01, {6'h00, vga_mem_reserve});
      @(posedge clock);
      ext_mode <= 1'b0;
      wr(8'h30, 8'h64);
      settle;
      chk("ext30", 8'h00, {5'h00, cursor_addr_a16, start_addr_a16, pixel_256color});
      chk("vga_mem_reserve", 8'h00, {6'h00, vga_mem_reserve});
      $display("test display done");
      for (i = 0; i < 16; i = i + 1) begin
         @(posedge clock);
         graphics_mode <= i[3];
         wr(8'h31, {1'b0, i[3], i[2:0], 1'b0, i[3], i[0]});
         settle;
         chk("scan", {3'h0, i[3], i[3], i[0], (i[3] && i[2:0] == 3'h1) || (!i[3] && i[2:0] == 3'h5),
             (i[3] && i[2:0] == 3'h2) || (!i[3] && i[2:0] == 3'h6)}, {3'h0, vtiming_div2,
             ega_reg_compat, ega_io_decode, scan_double, scan_3of4});
      end
      $display("test scan done");
      for (i = 0; i < 4; i = i + 1) begin
         @(posedge clock);
         separate_paging_select_reg <= i[0];
         aperture_128k_enable_reg <= i[1];
         wr(8'h32, i[1] ? 8'h0E : 8'hF0);
         settle;
         chk("write_block", i[1] ? 8'h07 : 8'h08, {4'h0, write_block});
         chk("read_block", {5'h00, {3{i[0] ^ i[1]}}}, {4'h0, read_block});
         chk("block_128k", {7'h00, i[1]}, {7'h00, block_128k});
      end
      $display("test paging done");
      for (i = 0; i < 4; i = i + 1) begin
         wr(8'h33, {i[0], i[1], i[0], 1'b0, 1'b1, 1'b0, i[1], i[0]});
         settle;
         chk("eeprom", {2'h0, i[0], i[1], i[0], 1'b1, i[1], i[0]}, {2'h0, short_screen_dblscan,
             one_bit_per_map, mem_16bit, eeprom_select, eeprom_clock, eeprom_data});
      end
      @(posedge clock);
      memwidth_strap_pin <= 1'b0;
      repeat (10) @(posedge clock);
      #1 chk("mem_16bit", 8'h00, {7'h00, mem_16bit});
      $display("test eeprom done");
      for (i = 0; i < 8; i = i + 1) begin
         @(posedge clock);
         display_enable <= i[2];
         wr(8'h35, {1'b0, i[0], 4'h0, i[1], i[0]});
         settle;
         chk("blank_out_n", {7'h00, (i[0] ? i[2] : 1'b1) ^ i[1]}, {7'h00, blank_out_n});
         chk("cursor_start", {3'h0, i[0] ? 5'h02 : 5'h1D}, {3'h0, cursor_start_out});
         chk("cursor_end", {3'h0, i[0] ? 5'h08 : 5'h03}, {3'h0, cursor_end_out});
      end
      $display("test blanking done");
      for (i = 0; i < 2; i = i + 1) begin
         d = i[0] ? 8'h55 : 8'h2A;
         wr(8'h34, d);
         wr(8'h36, d);
         settle;
         chk("protect", d & 8'h7C, {1'b0, wp_htiming, wp_row_underline, wp_cursor, wp_vtiming,
             wp_max_scan, 2'h0});
         chk("addr36", d & 8'h05, {5'h00, linear_256, 1'b0, addr_above_64k});
      end
      $display("test protect done");
      @(posedge clock);
      reset <= 1'b1;
      @(posedge clock);
      reset <= 1'b0;
      rd(8'h35, 8'h00);
      chk("blank_out_n", 8'h01, {7'h00, blank_out_n});
      $display("test rereset done");
      final_report;
   end
endmodule // tb
